/* brake_timer.sv */
`timescale 1ns/1ps
// Counts 100 ms steps from a restart until the limit is met.
module brake_timer #(
   parameter int STEP_CYCLES = 2_500_000
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       restart,
   input  wire logic [9:0] limit,
   output logic            done
);

   logic [21:0] pre;       // Cycles inside the current step.
   logic [21:0] next_pre;  // Next value of the prescaler.
   logic [9:0]  steps;     // Whole steps elapsed.
   logic [9:0]  next_steps; // Next value of the step count.

   // The count stops at the limit, so a long hold never wraps round.
   always_comb begin
      next_pre = pre;
      next_steps = steps;
      if (restart) begin
         next_pre = '0;
         next_steps = '0;
      end else if (steps < limit) begin
         if (pre == 22'(STEP_CYCLES - 1)) begin
            next_pre = '0;
            next_steps = steps + 10'h001;
         end else begin
            next_pre = pre + 22'h000001;
         end
      end
   end

   // Registers only.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pre <= '0;
         steps <= '0;
      end else begin
         pre <= next_pre;
         steps <= next_steps;
      end
   end

   // Done ignores restart: restart comes from the next state, which reads
   // done, so gating it here would close a combinational loop.
   assign done = (steps >= limit);

endmodule // brake_timer

/* dc_brake_ctrl.sv */
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Brake below threshold frequency while decelerating.
// - Coast for the wait delay first.
// - Wait starts at threshold or external input.
// - Stop braking uses the stop force.
// - Stop braking lasts the stop duration.
// - Optional start braking before accelerating.
// - Enable code 01 turns on internal braking.
// - External input overrides enable and durations.
// - Trigger kind: 00 edge, 01 level.
// - Level mode brakes while input is on.
// - Edge mode brakes until the motor stops.
// - Edge mode ignores edges while stopped.
// - Braking uses its own carrier frequency.
// - Higher braking carrier derates the force.
module dc_brake_ctrl
   import dc_brake_pkg::*;
#(
   parameter int         STEP_CYC    = dc_brake_pkg::STEP_CYCLES,
   parameter logic [6:0] CARRIER_TOP = dc_brake_pkg::CARRIER_SMALL
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [31:0] rdata,
   input  wire logic        run_cmd,
   input  wire logic        decel,
   input  wire logic [15:0] out_freq,
   input  wire logic        motor_stopped,
   input  wire logic        ext_brake_input,
   input  wire logic [6:0]  main_output_carrier,
   output logic             brake_inject,
   output logic             drive_coast,
   output logic             drive_run,
   output logic      [6:0]  force_cmd,
   output logic      [6:0]  carrier_cmd
);
   import dc_brake_pkg::*;

   // Saturates a written value at its largest legal setting.
   function automatic logic [12:0] clamp(input logic [12:0] v,
                                         input logic [12:0] top);
      clamp = (v > top) ? top : v;
   endfunction

   // Largest force the braking carrier allows.
   function automatic logic [6:0] force_limit(input logic [6:0] car);
      logic [6:0] cut;
      cut = '0;
      if (car > DERATE_KNEE) begin
         cut = (car - DERATE_KNEE) / DERATE_STEP;
      end
      if (cut > FORCE_MAX - DERATE_FLOOR) begin
         force_limit = DERATE_FLOOR;
      end else begin
         force_limit = FORCE_MAX - cut;
      end
   endfunction

   // Settings held by software.
   logic [1:0]  enable_sel;           // Internal braking enable code.
   logic [1:0]  ext_trigger_kind;     // Edge or level for the input.
   logic        stop_en;              // Internal braking at stopping.
   logic        start_en;             // Internal braking at starting.
   logic [7:0]  term_func;            // Function code of the input.
   logic [12:0] brake_threshold_freq; // Threshold in 0.01 Hz.
   logic [5:0]  brake_wait_delay;     // Coast time in 0.1 s.
   logic [6:0]  stop_brake_force;     // Percent.
   logic [9:0]  stop_brake_duration;  // 0.1 s.
   logic [6:0]  start_brake_force;    // Percent.
   logic [9:0]  start_brake_duration; // 0.1 s.
   logic [6:0]  brake_carrier_freq;   // 0.1 kHz.
   logic [31:0] next_rdata;           // Read data for the next cycle.
   logic [12:0] wr_val;               // Low write bits before saturating.

   // Sequencer and input pipeline.
   brake_state_e state;       // Present sequencer state.
   brake_state_e next_state;  // State at the next edge.
   logic        ext_meta;     // First synchroniser stage.
   logic        ext_sync;     // Input safe to use.
   logic        ext_prev;     // Delayed copy for the edge.
   logic        run_prev;     // Delayed run command.
   logic        ext_rise;     // Off-to-on of the external input.
   logic        run_rise;     // Fresh run command.
   logic        ext_mode;     // Terminal assigned to braking.
   logic        int_mode;     // Internal braking enabled.
   logic        below_thr;    // Output frequency under threshold.
   logic        timer_done;   // Timed interval complete.
   logic        timer_go;     // Restart on each state change.
   logic        has_wait;     // A nonzero wait delay is set.
   logic [9:0]  timer_lim;    // Limit for the present state.
   logic [6:0]  lim;          // Derated force ceiling.
   logic [6:0]  stop_lim;     // Stop force after derating.
   logic [6:0]  start_lim;    // Start force after derating.
   logic        next_inject;  // Next DC injection output.
   logic        next_coast;   // Next coast output.
   logic        next_run;     // Next normal output.
   logic [6:0]  next_force;   // Next force command.
   logic [6:0]  next_carrier; // Next carrier command.

   // Register writes and reads; unmapped addresses read as zero.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         enable_sel <= RST_ENABLE_SEL;
         ext_trigger_kind <= RST_TRIG_KIND;
         stop_en <= RST_STOP_EN;
         start_en <= RST_START_EN;
         term_func <= RST_TERM_FUNC;
         brake_threshold_freq <= RST_THRESHOLD;
         brake_wait_delay <= RST_WAIT;
         stop_brake_force <= RST_FORCE;
         stop_brake_duration <= RST_DUR;
         start_brake_force <= RST_FORCE;
         start_brake_duration <= RST_DUR;
         brake_carrier_freq <= RST_CARRIER;
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
         if (wr_en) begin
            case (addr)
               OFS_CTRL: begin
                  enable_sel <= wdata[POS_ENABLE_SEL +: 2];
                  ext_trigger_kind <= wdata[POS_TRIG_KIND +: 2];
                  stop_en <= wdata[POS_STOP_EN];
                  start_en <= wdata[POS_START_EN];
                  term_func <= wdata[POS_TERM_FUNC +: 8];
               end
               OFS_THRESHOLD: begin
                  brake_threshold_freq <= clamp(wr_val, THRESHOLD_MAX);
               end
               OFS_WAIT: begin
                  brake_wait_delay <= 6'(clamp(wr_val, 13'(WAIT_MAX)));
               end
               OFS_STOP_FORCE: begin
                  stop_brake_force <= 7'(clamp(wr_val, 13'(FORCE_MAX)));
               end
               OFS_STOP_DUR: begin
                  stop_brake_duration <= 10'(clamp(wr_val, 13'(DUR_MAX)));
               end
               OFS_STA_FORCE: begin
                  start_brake_force <= 7'(clamp(wr_val, 13'(FORCE_MAX)));
               end
               OFS_STA_DUR: begin
                  start_brake_duration <= 10'(clamp(wr_val, 13'(DUR_MAX)));
               end
               OFS_CARRIER: begin
                  // The carrier stays inside the range of this frame size.
                  if (wr_val < 13'(CARRIER_MIN)) begin
                     brake_carrier_freq <= CARRIER_MIN;
                  end else begin
                     brake_carrier_freq <= 7'(clamp(wr_val, 13'(CARRIER_TOP)));
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Read multiplexer; data show only in the cycle after the strobe.
   always_comb begin
      next_rdata = '0;
      if (rd_en) begin
         case (addr)
            OFS_CTRL: begin
               next_rdata[POS_ENABLE_SEL +: 2] = enable_sel;
               next_rdata[POS_TRIG_KIND +: 2] = ext_trigger_kind;
               next_rdata[POS_STOP_EN] = stop_en;
               next_rdata[POS_START_EN] = start_en;
               next_rdata[POS_TERM_FUNC +: 8] = term_func;
            end
            OFS_THRESHOLD:  next_rdata[12:0] = brake_threshold_freq;
            OFS_WAIT:       next_rdata[5:0] = brake_wait_delay;
            OFS_STOP_FORCE: next_rdata[6:0] = stop_brake_force;
            OFS_STOP_DUR:   next_rdata[9:0] = stop_brake_duration;
            OFS_STA_FORCE:  next_rdata[6:0] = start_brake_force;
            OFS_STA_DUR:    next_rdata[9:0] = start_brake_duration;
            OFS_CARRIER:    next_rdata[6:0] = brake_carrier_freq;
            OFS_STATUS: begin
               next_rdata[POS_ST_STATE +: 3] = state;
               next_rdata[POS_ST_INJECT] = brake_inject;
               next_rdata[POS_ST_EXT] = ext_sync;
               next_rdata[POS_ST_FORCE +: 7] = force_cmd;
            end
            default: next_rdata = '0;
         endcase
      end
   end

   // Mode decode and derated force ceilings.
   assign ext_mode = (term_func == FUNC_EXT_BRAKE);
   assign int_mode = !ext_mode && (enable_sel == ENABLE_ON);
   assign below_thr = (out_freq < 16'(brake_threshold_freq));
   assign ext_rise = ext_sync && !ext_prev;
   assign run_rise = run_cmd && !run_prev;
   assign lim = force_limit(brake_carrier_freq);
   assign stop_lim = (stop_brake_force > lim) ? lim : stop_brake_force;
   assign start_lim = (start_brake_force > lim) ? lim : start_brake_force;
   assign timer_go = (next_state != state);
   assign wr_val = wdata[12:0];
   assign has_wait = (brake_wait_delay != '0);

   // One timer serves the wait and both timed braking intervals.
   always_comb begin
      case (state)
         ST_WAIT:   timer_lim = 10'(brake_wait_delay);
         ST_STOPBR: timer_lim = stop_brake_duration;
         ST_STARTB: timer_lim = start_brake_duration;
         default:   timer_lim = '0;
      endcase
   end

   brake_timer #(
      .STEP_CYCLES (STEP_CYC)
   ) u_timer (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .restart (timer_go),
      .limit   (timer_lim),
      .done    (timer_done)
   );

   // Sequencer. External triggering outranks internal settings.
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            // Edge mode has no branch here, so a rise while stopped is lost.
            if (ext_mode && ext_trigger_kind == TRIG_LEVEL && ext_sync) begin
               next_state = has_wait ? ST_WAIT : ST_EXTLVL;
            end else if (run_cmd) begin
               if (int_mode && start_en && run_rise &&
                   start_brake_duration != '0) begin
                  next_state = ST_STARTB;
               end else begin
                  next_state = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            if (ext_mode && ext_trigger_kind == TRIG_LEVEL && ext_sync) begin
               next_state = has_wait ? ST_WAIT : ST_EXTLVL;
            end else if (ext_mode && ext_trigger_kind == TRIG_EDGE &&
                         ext_rise) begin
               next_state = has_wait ? ST_WAIT : ST_EXTEDG;
            end else if (int_mode && stop_en && decel && below_thr &&
                         stop_brake_duration != '0) begin
               next_state = has_wait ? ST_WAIT : ST_STOPBR;
            end else if (!run_cmd && motor_stopped) begin
               next_state = ST_IDLE;
            end
         end
         ST_WAIT: begin
            // The delay runs from the trigger that led here.
            if (ext_mode && ext_trigger_kind == TRIG_LEVEL && !ext_sync) begin
               next_state = ST_IDLE;
            end else if (timer_done) begin
               if (!ext_mode) begin
                  next_state = ST_STOPBR;
               end else if (ext_trigger_kind == TRIG_LEVEL) begin
                  next_state = ST_EXTLVL;
               end else begin
                  next_state = ST_EXTEDG;
               end
            end
         end
         ST_STOPBR: begin
            if (timer_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_STARTB: begin
            if (timer_done) begin
               next_state = run_cmd ? ST_RUN : ST_IDLE;
            end
         end
         ST_EXTLVL: begin
            if (!ext_sync) begin
               next_state = ST_IDLE;
            end
         end
         ST_EXTEDG: begin
            if (motor_stopped) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Drive commands follow the state being entered.
   always_comb begin
      next_inject = 1'b0;
      next_coast = 1'b0;
      next_run = 1'b0;
      next_force = '0;
      next_carrier = main_output_carrier;
      case (next_state)
         ST_RUN: next_run = 1'b1;
         ST_WAIT: next_coast = 1'b1;
         ST_STOPBR, ST_EXTEDG: begin
            next_inject = 1'b1;
            next_force = stop_lim;
            next_carrier = brake_carrier_freq;
         end
         ST_STARTB: begin
            next_inject = 1'b1;
            next_force = start_lim;
            next_carrier = brake_carrier_freq;
         end
         ST_EXTLVL: begin
            // Force depends on whether the drive is asked to run.
            next_inject = 1'b1;
            next_force = run_cmd ? start_lim : stop_lim;
            next_carrier = brake_carrier_freq;
         end
         default: next_coast = 1'b0;
      endcase
   end

   // State, synchroniser and output registers.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_prev <= 1'b0;
         run_prev <= 1'b0;
         brake_inject <= 1'b0;
         drive_coast <= 1'b0;
         drive_run <= 1'b0;
         force_cmd <= '0;
         carrier_cmd <= '0;
      end else begin
         state <= next_state;
         ext_meta <= ext_brake_input;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
         run_prev <= run_cmd;
         brake_inject <= next_inject;
         drive_coast <= next_coast;
         drive_run <= next_run;
         force_cmd <= next_force;
         carrier_cmd <= next_carrier;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_stop_end;
      (state == ST_STOPBR) && timer_done;
   endsequence

   sequence s_settled_idle;
      (state == ST_IDLE) && !brake_inject;
   endsequence

   a_thresh_entry: assert property (
      (state == ST_RUN) && int_mode && stop_en && decel && below_thr &&
      stop_brake_duration != '0 && !ext_mode
      |=> (state == ST_WAIT) || (state == ST_STOPBR))
      else $error("threshold did not start braking");
   a_wait_coast: assert property (
      (state == ST_WAIT) |-> drive_coast && !brake_inject && !drive_run)
      else $error("wait is not coasting");
   a_wait_ends: assert property (
      (state == ST_WAIT) && timer_done && !ext_mode |=> state == ST_STOPBR)
      else $error("wait overran");
   a_stop_force: assert property (
      (next_state == ST_STOPBR) |=> force_cmd == $past(stop_lim))
      else $error("wrong stop force");
   a_stop_hold: assert property (
      (state == ST_STOPBR) && !timer_done |=> state == ST_STOPBR)
      else $error("stop braking cut short");
   a_start_brake: assert property (
      (state == ST_IDLE) && int_mode && start_en && run_cmd && run_rise &&
      start_brake_duration != '0 && !ext_sync
      |=> (state == ST_STARTB) && brake_inject)
      else $error("start braking missing");
   a_ext_no_timed: assert property (
      ext_mode && (state == ST_IDLE || state == ST_RUN)
      |=> state != ST_STOPBR && state != ST_STARTB)
      else $error("timed braking in external mode");
   a_level_follow: assert property (
      (state == ST_EXTLVL) && !ext_sync |=> !brake_inject)
      else $error("level braking outlived input");
   a_edge_stop: assert property (
      (state == ST_EXTEDG) && motor_stopped |=> s_settled_idle)
      else $error("edge braking did not end");
   a_edge_ignored: assert property (
      (state == ST_IDLE) && ext_mode && ext_trigger_kind == TRIG_EDGE
      |=> !brake_inject)
      else $error("edge honoured while stopped");
   a_brake_carrier: assert property (
      brake_inject |-> carrier_cmd == $past(brake_carrier_freq))
      else $error("braking not on its carrier");
   a_derate_cap: assert property (
      brake_inject |-> force_cmd <= $past(lim))
      else $error("force above derated limit");
   a_stop_release: assert property (
      s_stop_end |=> s_settled_idle ##1 (state == ST_IDLE || state == ST_RUN
      || state == ST_STARTB || state == ST_EXTLVL))
      else $error("no release after stop braking");

endmodule // dc_brake_ctrl

/* dc_brake_pkg.sv */
package dc_brake_pkg;

   // Register byte offsets on the plain register port.
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_THRESHOLD  = 8'h04;
   localparam logic [7:0] OFS_WAIT       = 8'h08;
   localparam logic [7:0] OFS_STOP_FORCE = 8'h0C;
   localparam logic [7:0] OFS_STOP_DUR   = 8'h10;
   localparam logic [7:0] OFS_STA_FORCE  = 8'h14;
   localparam logic [7:0] OFS_STA_DUR    = 8'h18;
   localparam logic [7:0] OFS_CARRIER    = 8'h1C;
   localparam logic [7:0] OFS_STATUS     = 8'h20;

   // Field positions inside the control and status words.
   localparam int POS_ENABLE_SEL = 0;
   localparam int POS_TRIG_KIND  = 4;
   localparam int POS_STOP_EN    = 8;
   localparam int POS_START_EN   = 9;
   localparam int POS_TERM_FUNC  = 16;
   localparam int POS_ST_STATE   = 0;
   localparam int POS_ST_INJECT  = 4;
   localparam int POS_ST_EXT     = 5;
   localparam int POS_ST_FORCE   = 8;

   // Setting codes.
   localparam logic [1:0] ENABLE_OFF     = 2'h0;
   localparam logic [1:0] ENABLE_ON      = 2'h1;
   localparam logic [1:0] TRIG_EDGE      = 2'h0;
   localparam logic [1:0] TRIG_LEVEL     = 2'h1;
   localparam logic [7:0] FUNC_EXT_BRAKE = 8'h07;

   // Reset values (frequency in 0.01 Hz, times in 0.1 s, carrier 0.1 kHz).
   localparam logic [1:0]  RST_ENABLE_SEL = ENABLE_OFF;
   localparam logic [1:0]  RST_TRIG_KIND  = TRIG_LEVEL;
   localparam logic        RST_STOP_EN    = 1'b1;
   localparam logic        RST_START_EN   = 1'b0;
   localparam logic [7:0]  RST_TERM_FUNC  = 8'h00;
   localparam logic [12:0] RST_THRESHOLD  = 13'h0032;
   localparam logic [5:0]  RST_WAIT       = 6'h00;
   localparam logic [6:0]  RST_FORCE      = 7'h00;
   localparam logic [9:0]  RST_DUR        = 10'h000;
   localparam logic [6:0]  RST_CARRIER    = 7'h1E;

   // Setting limits.
   localparam logic [12:0] THRESHOLD_MAX = 13'h1770;
   localparam logic [5:0]  WAIT_MAX      = 6'h32;
   localparam logic [6:0]  FORCE_MAX     = 7'h46;
   localparam logic [9:0]  DUR_MAX       = 10'h258;
   localparam logic [6:0]  CARRIER_MIN   = 7'h05;
   localparam logic [6:0]  CARRIER_SMALL = 7'h78;

   // Force derating against braking carrier, in 0.1 kHz and percent.
   localparam logic [6:0] DERATE_KNEE  = 7'h1E;
   localparam logic [6:0] DERATE_STEP  = 7'h02;
   localparam logic [6:0] DERATE_FLOOR = 7'h0A;

   // Time base: one setting step is 100 ms of a 25 MHz clock.
   localparam int CLK_HZ       = 25_000_000;
   localparam int STEP_TIME_MS = 100;
   localparam int STEP_CYCLES  = CLK_HZ / 1000 * STEP_TIME_MS;

   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_RUN    = 3'b001,
      ST_WAIT   = 3'b010,
      ST_STOPBR = 3'b011,
      ST_STARTB = 3'b100,
      ST_EXTLVL = 3'b101,
      ST_EXTEDG = 3'b110
   } brake_state_e;

endpackage

/* dc_injection_braking_control_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the braking sequencer with a motor model.
module dc_injection_braking_control_tb_top;
   import dc_brake_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic        run_cmd = 1'b0;
   logic        ext_brake_input = 1'b0;
   logic [6:0]  main_output_carrier = 7'h28;
   logic [31:0] rdata;
   logic        decel, motor_stopped, brake_inject, drive_coast, drive_run;
   logic [15:0] out_freq;
   logic [6:0]  force_cmd, carrier_cmd, f, g, c;
   logic [31:0] seed = 32'h2EED7DC2;  // Fixed seed keeps runs repeatable.
   int          n_fail = 0;
   int          compares = 0;
   int          cnt, cc;

   dc_brake_ctrl #(.STEP_CYC(4)) uut (.clk_sys(clk_sys), .rst_b(rst_b),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .run_cmd(run_cmd), .decel(decel), .out_freq(out_freq),
      .motor_stopped(motor_stopped), .ext_brake_input(ext_brake_input),
      .main_output_carrier(main_output_carrier),
      .brake_inject(brake_inject), .drive_coast(drive_coast),
      .drive_run(drive_run), .force_cmd(force_cmd),
      .carrier_cmd(carrier_cmd));
   motor_load u_motor (.clk_sys(clk_sys), .run_cmd(run_cmd),
      .drive_run(drive_run), .drive_coast(drive_coast),
      .brake_inject(brake_inject), .out_freq(out_freq), .decel(decel),
      .motor_stopped(motor_stopped));

   // 25 MHz system clock.
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Force limit shrinks half a percent per 0.1 kHz above 3 kHz.
   function automatic logic [6:0] exp_force(logic [6:0] fr, logic [6:0] cr);
      logic [6:0] lim;
      lim = (cr <= 7'h1E) ? 7'h46 : 7'h46 - (cr - 7'h1E) / 2;
      if (lim < 7'h0A) lim = 7'h0A;
      return (fr < lim) ? fr : lim;
   endfunction

   task automatic test_done();
      if (n_fail == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask

   // Steps past an edge so registered outputs have settled.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      tick(1);
      wr_en <= 1'b0;
      tick(1);
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      addr <= a;
      rd_en <= 1'b1;
      tick(1);
      rd_en <= 1'b0;
      chk(rdata === e, "read data");
      tick(1);
   endtask

   // Bounded wait for injection to reach v, counting coasting cycles.
   task automatic wait_inj(input logic v, input int lim);
      cnt = 0;
      cc = 0;
      while (brake_inject !== v && cnt < lim) begin
         if (drive_coast === 1'b1) cc++;
         tick(1);
         cnt++;
      end
      if (brake_inject !== v) begin
         chk(1'b0, "wait timed out");
         test_done();
      end
   endtask

   task automatic watch(input int n);
      cnt = 0;
      repeat (n) begin
         tick(1);
         if (brake_inject === 1'b1) cnt++;
      end
   endtask

   initial begin
      main_output_carrier <= 7'(5 + rnd() % 100);
      tick(5);
      rst_b <= 1'b1;
      tick(2);
      chk(carrier_cmd === main_output_carrier, "idle carrier");
      rd(OFS_CTRL, 32'h00000110);
      rd(OFS_THRESHOLD, 32'h00000032);
      rd(OFS_CARRIER, 32'h0000001E);
      rd(8'h24, 32'h00000000);
      wr(OFS_STOP_DUR, 32'h000003FF);
      rd(OFS_STOP_DUR, {22'h0, DUR_MAX});
      wr(OFS_THRESHOLD, 32'h000001F4);
      // Stop braking with growing wait and duration, random force.
      for (int k = 0; k < 3; k++) begin
         f = 7'(rnd() % 71);
         c = 7'(5 + rnd() % 116);
         wr(OFS_STOP_FORCE, {25'h0, f});
         wr(OFS_CARRIER, {25'h0, c});
         wr(OFS_WAIT, k);
         wr(OFS_STOP_DUR, 2 + k);
         wr(OFS_CTRL, 32'h00000101);
         run_cmd <= 1'b1;
         tick(80);
         run_cmd <= 1'b0;
         wait_inj(1'b1, 300);
         chk(cc >= 4 * k && cc <= 4 * k + 1, "coast time");
         chk(force_cmd === exp_force(f, c), "force");
         chk(carrier_cmd === c, "carrier");
         wait_inj(1'b0, 100);
         chk(cnt >= 8 + 4 * k && cnt <= 10 + 4 * k, "duration");
         chk(drive_run === 1'b0, "stays stopped");
         tick(60);
      end
      // Disabled: no braking at all.
      wr(OFS_CTRL, 32'h00000100);
      run_cmd <= 1'b1;
      tick(80);
      run_cmd <= 1'b0;
      watch(150);
      chk(cnt == 0, "disabled");
      // Start braking, then acceleration.
      g = 7'(rnd() % 71);
      wr(OFS_STA_FORCE, {25'h0, g});
      wr(OFS_STA_DUR, 32'h00000002);
      wr(OFS_CTRL, 32'h00000201);
      run_cmd <= 1'b1;
      wait_inj(1'b1, 5);
      chk(force_cmd === exp_force(g, c) && drive_run === 1'b0, "start");
      wait_inj(1'b0, 20);
      chk(cnt >= 8 && cnt <= 10, "start time");
      tick(2);
      chk(drive_run === 1'b1, "accelerate");
      wr(OFS_CTRL, 32'h00000000);
      run_cmd <= 1'b0;
      tick(100);
      // Level mode ignores enable and durations.
      wr(OFS_CTRL, 32'h00070010);
      wr(OFS_WAIT, 32'h00000000);
      ext_brake_input <= 1'b1;
      wait_inj(1'b1, 4);
      chk(force_cmd === exp_force(f, c), "level force");
      watch(20);
      chk(cnt == 20, "level hold");
      rd(OFS_STATUS, {17'h0, exp_force(f, c), 8'h35});
      ext_brake_input <= 1'b0;
      tick(4);
      chk(brake_inject === 1'b0, "level off");
      // Edge mode: ignored when stopped, brakes to standstill when running.
      wr(OFS_CTRL, 32'h00070000);
      ext_brake_input <= 1'b1;
      watch(10);
      chk(cnt == 0, "edge in stop");
      ext_brake_input <= 1'b0;
      run_cmd <= 1'b1;
      tick(60);
      ext_brake_input <= 1'b1;
      wait_inj(1'b1, 5);
      run_cmd <= 1'b0;
      ext_brake_input <= 1'b0;
      wait_inj(1'b0, 300);
      chk(motor_stopped === 1'b1 && cnt > 20, "edge brake");
      test_done();
   end
endmodule  // dc_injection_braking_control_tb_top

/* motor_load.sv */
`timescale 1ns/1ps
// Behavioural motor and load: the shaft speed follows the drive outputs.
module motor_load (
   input  wire logic        clk_sys,
   input  wire logic        run_cmd,
   input  wire logic        drive_run,
   input  wire logic        drive_coast,
   input  wire logic        brake_inject,
   output logic      [15:0] out_freq,
   output logic             decel,
   output logic             motor_stopped
);
   logic [15:0] spd = 16'h0000;  // Shaft speed in 0.01 Hz.

   // Speed step down that never wraps below zero.
   function automatic logic [15:0] dn(input logic [15:0] d);
      return (spd > d) ? spd - d : 16'h0000;
   endfunction

   // Injection stops the shaft fastest; a coasting shaft barely slows.
   always @(posedge clk_sys) begin
      if (brake_inject) spd <= dn(16'h003C);
      else if (drive_coast) spd <= dn(16'h0002);
      else if (drive_run && run_cmd && spd < 16'h07D0) spd <= spd + 16'h0028;
      else if (!(drive_run && run_cmd)) spd <= dn(16'h0028);
   end

   assign out_freq      = spd;
   assign decel         = !run_cmd && spd != 16'h0000;
   assign motor_stopped = spd == 16'h0000;
endmodule  // motor_load
